// ### gpx_cfg.svh
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH
`define GPX_ADDR_FIXED   4'h7
`define GPX_REG_INPUT    2'h0
`define GPX_REG_OUTPUT   2'h1
`define GPX_REG_POLARITY 2'h2
`define GPX_REG_DIR      2'h3
`define GPX_RST_OUTPUT   8'hff
`define GPX_RST_POLARITY 8'h00
`define GPX_RST_DIR      8'hff
`endif

// ### gpx_pkg.sv
package gpx_pkg;
   typedef enum logic [2:0] {
      GPX_IDLE,
      GPX_ADDR,
      GPX_ACK,
      GPX_WRITE,
      GPX_READ,
      GPX_RACK,
      GPX_SKIP
   } gpx_state_t;
   typedef struct packed {
      logic [7:0] output_val;
      logic [7:0] polarity;
      logic [7:0] direction;
      logic [1:0] reg_select;
   } gpx_regs_t;
endpackage

// ### gpx_expander.sv
`timescale 1ns/100ps
`include "gpx_cfg.svh"
module gpx_expander (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       addr_sel_0,
   input  wire logic       addr_sel_1,
   input  wire logic       addr_sel_2,
   input  wire logic [7:0] port_in,
   output logic      [7:0] high_side_driver,
   output logic      [7:0] low_side_driver,
   output logic      [7:0] port_oe,
   output logic            alert_out,
   output logic            alert_oe
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [12:0] sync1;
   logic [12:0] sync2;
   logic        scl_d;
   logic        sda_d;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         // Bus lines reset to their idle high level so no false edge follows reset
         sync1 <= 13'h0300;
         sync2 <= 13'h0300;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (clk_en) begin
         sync1 <= {addr_sel_2, addr_sel_1, addr_sel_0, sda_in, scl_in, port_in};
         sync2 <= sync1;
         scl_d <= sync2[8];
         sda_d <= sync2[9];
      end
   end
   logic [7:0] pins;
   logic       scl;
   logic       sda;
   logic [2:0] addr_pins;
   assign pins      = sync2[7:0];
   assign scl       = sync2[8];
   assign sda       = sync2[9];
   assign addr_pins = sync2[12:10];
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
   assign start_c  = scl & scl_d & sda_d & ~sda;
   assign stop_c   = scl & scl_d & ~sda_d & sda;

   // ****************************************
   // Serial slave and registers
   // ****************************************
   gpx_pkg::gpx_state_t state;
   gpx_pkg::gpx_state_t next_state;
   gpx_pkg::gpx_regs_t  regs;
   gpx_pkg::gpx_regs_t  next_regs;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic       is_read;
   logic       next_is_read;
   logic       have_cmd;
   logic       next_have_cmd;
   logic       drive_low;
   logic       next_drive_low;
   logic [7:0] captured;
   logic [7:0] next_captured;
   logic       alert;
   logic       next_alert;
   logic       port_oe_r;
   logic [1:0] warm_cnt;
   logic [7:0] read_val;

   // Reads of the input register return the synchronised pin levels through the polarity mask
   always_comb begin
      if (regs.reg_select == `GPX_REG_INPUT) begin
         read_val = pins ^ regs.polarity;
      end else if (regs.reg_select == `GPX_REG_OUTPUT) begin
         read_val = regs.output_val;
      end else if (regs.reg_select == `GPX_REG_POLARITY) begin
         read_val = regs.polarity;
      end else begin
         read_val = regs.direction;
      end
   end

   always_comb begin
      next_state     = state;
      next_regs      = regs;
      next_shift     = shift;
      next_bitcnt    = bitcnt;
      next_is_read   = is_read;
      next_have_cmd  = have_cmd;
      next_drive_low = drive_low;
      next_captured  = captured;
      if (start_c) begin
         next_state     = gpx_pkg::GPX_ADDR;
         next_bitcnt    = 4'h0;
         next_drive_low = 1'b0;
      end else if (stop_c) begin
         next_state     = gpx_pkg::GPX_IDLE;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            gpx_pkg::GPX_ADDR, gpx_pkg::GPX_WRITE: begin
               if (scl_rise) begin
                  next_shift  = {shift[6:0], sda};
                  next_bitcnt = bitcnt + 4'h1;
               end
               if (scl_fall && bitcnt == 4'h8) begin
                  next_bitcnt = 4'h0;
                  if (state == gpx_pkg::GPX_ADDR) begin
                     // Address match on fixed bits and pin bits
                     if (shift[7:1] == {`GPX_ADDR_FIXED, addr_pins}) begin
                        next_is_read   = shift[0];
                        next_have_cmd  = 1'b0;
                        next_drive_low = 1'b1;
                        next_state     = gpx_pkg::GPX_ACK;
                     end else begin
                        next_state = gpx_pkg::GPX_SKIP;
                     end
                  end else begin
                     next_drive_low = 1'b1;
                     next_state     = gpx_pkg::GPX_ACK;
                     if (!have_cmd) begin
                        next_regs.reg_select = shift[1:0];
                        next_have_cmd        = 1'b1;
                     end else if (regs.reg_select == `GPX_REG_OUTPUT) begin
                        next_regs.output_val = shift;
                     end else if (regs.reg_select == `GPX_REG_POLARITY) begin
                        next_regs.polarity = shift;
                     end else if (regs.reg_select == `GPX_REG_DIR) begin
                        next_regs.direction = shift;
                     end
                  end
               end
            end
            gpx_pkg::GPX_ACK: begin
               if (scl_fall) begin
                  if (is_read) begin
                     next_shift     = read_val;
                     next_drive_low = ~read_val[7];
                     next_bitcnt    = 4'h1;
                     next_state     = gpx_pkg::GPX_READ;
                     if (regs.reg_select == `GPX_REG_INPUT) begin
                        next_captured = pins;
                     end
                  end else begin
                     next_drive_low = 1'b0;
                     next_state     = gpx_pkg::GPX_WRITE;
                  end
               end
            end
            gpx_pkg::GPX_READ: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     next_drive_low = 1'b0;
                     next_state     = gpx_pkg::GPX_RACK;
                  end else begin
                     next_shift     = {shift[6:0], 1'b0};
                     next_drive_low = ~shift[6];
                     next_bitcnt    = bitcnt + 4'h1;
                  end
               end
            end
            gpx_pkg::GPX_RACK: begin
               if (scl_rise) begin
                  // A master NACK ends the read
                  next_state = sda ? gpx_pkg::GPX_SKIP : gpx_pkg::GPX_ACK;
               end
            end
            default: begin
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   // Input capture on power-up is the live level so the alert starts quiet
   always_comb begin
      next_alert = (pins != captured);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state                <= gpx_pkg::GPX_IDLE;
         regs.output_val      <= `GPX_RST_OUTPUT;
         regs.polarity        <= `GPX_RST_POLARITY;
         regs.direction       <= `GPX_RST_DIR;
         regs.reg_select      <= `GPX_REG_INPUT;
         shift                <= 8'h00;
         bitcnt               <= 4'h0;
         is_read              <= 1'b0;
         have_cmd             <= 1'b0;
         drive_low            <= 1'b0;
         captured             <= 8'h00;
         alert                <= 1'b0;
         port_oe_r            <= 1'b0;
         warm_cnt             <= 2'h0;
      end else if (clk_en) begin
         state     <= next_state;
         regs      <= next_regs;
         shift     <= next_shift;
         bitcnt    <= next_bitcnt;
         is_read   <= next_is_read;
         have_cmd  <= next_have_cmd;
         drive_low <= next_drive_low;
         // Capture keeps following the pins until both synchroniser stages hold live levels
         captured  <= port_oe_r ? next_captured : pins;
         alert     <= port_oe_r ? next_alert : 1'b0;
         warm_cnt  <= {warm_cnt[0], 1'b1};
         port_oe_r <= warm_cnt[1];
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   logic [7:0] hs_r;
   logic [7:0] ls_r;
   logic [7:0] oe_r;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               hs_r[gi] <= 1'b0;
               ls_r[gi] <= 1'b0;
               oe_r[gi] <= 1'b0;
            end else if (clk_en) begin
               // Direction bit one means input: both drivers off
               hs_r[gi] <= ~next_regs.direction[gi] & next_regs.output_val[gi];
               ls_r[gi] <= ~next_regs.direction[gi] & ~next_regs.output_val[gi];
               oe_r[gi] <= ~next_regs.direction[gi];
            end
         end
      end
   endgenerate

   assign high_side_driver = hs_r;
   assign low_side_driver  = ls_r;
   assign port_oe          = oe_r;
   assign sda_out          = 1'b0;
   assign sda_oe           = drive_low;
   assign alert_out        = 1'b0;
   assign alert_oe         = alert;

   // ****************************************
   // Checks
   // ****************************************
   a_input_hiz: assert property (@(posedge clock) disable iff (!nrst)
      regs.direction == 8'hff |-> (port_oe == 8'h00)) else $error("input pin driven");
   a_drive_excl: assert property (@(posedge clock) disable iff (!nrst)
      (high_side_driver & low_side_driver) == 8'h00) else $error("both drivers on");
   a_out_value: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && $stable(regs) |=> (high_side_driver == (~regs.direction & regs.output_val)))
      else $error("output level wrong");
   a_alert_set: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && port_oe_r && (pins != captured) |=> alert_oe) else $error("alert missing");
   a_alert_open: assert property (@(posedge clock) disable iff (!nrst)
      alert_out == 1'b0) else $error("alert drives high");
   a_dir_write: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && !$stable(regs.direction) |-> $past(state) == gpx_pkg::GPX_WRITE)
      else $error("direction changed outside write");
   a_cmd_hold: assert property (@(posedge clock) disable iff (!nrst)
      !$stable(regs.reg_select) |-> !$past(have_cmd)) else $error("select changed");
   a_read_ack: assert property (@(posedge clock) disable iff (!nrst)
      state == gpx_pkg::GPX_ACK && clk_en && !start_c && !stop_c |-> sda_oe)
      else $error("ack not driven");
   c_ack: cover property (@(posedge clock) state == gpx_pkg::GPX_ACK);
   c_read: cover property (@(posedge clock) state == gpx_pkg::GPX_READ);
   c_alert: cover property (@(posedge clock) alert_oe);
   c_out: cover property (@(posedge clock) port_oe != 8'h00);
endmodule

// ### gpx_host_model.sv
`timescale 1ns/100ps
// ********************************************
// Bus master model, SCL period 25 clocks
// ********************************************
module gpx_host_model (
   input  wire logic clock,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic pause(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Works from idle and as a repeated start
   task automatic start();
      sda_low = 1'b0;
      pause(6);
      scl = 1'b1;
      pause(12);
      sda_low = 1'b1;
      pause(12);
      scl = 1'b0;
      pause(6);
   endtask
   task automatic stop();
      sda_low = 1'b1;
      pause(6);
      scl = 1'b1;
      pause(12);
      sda_low = 1'b0;
      pause(12);
   endtask
   // SDA moves only while SCL is low, so no false start or stop
   task automatic bit_cycle(input logic b, output logic r);
      sda_low = ~b;
      pause(6);
      scl = 1'b1;
      pause(6);
      r = sda_line;
      pause(6);
      scl = 1'b0;
      pause(7);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(tx[i], r);
         rx[i] = r;
      end
      bit_cycle(nb, r);
      ack = ~r;
   endtask
endmodule

// ### i2c_octal_io_expander_bench.sv
`timescale 1ns/100ps
`include "gpx_cfg.svh"
// ********************************************
// Bench
// ********************************************
module i2c_octal_io_expander_bench;
   logic       clock    = 1'b0;
   logic       nrst     = 1'b0;
   logic [2:0] asel     = 3'h0;
   logic [7:0] ext      = 8'hff;
   logic [7:0] hs, ls, poe, m_out, m_pol, m_dir, rx;
   logic       sda_oe, alert_oe, alert_out, sda_out, scl, sda_low, ack;
   logic [1:0] m_sel;
   int         n_errors = 0;
   int         checked  = 0;
   int         seed     = 84;
   int         v;
   wire        sda      = ~sda_low & (sda_oe ? sda_out : 1'b1);
   wire  [7:0] pins     = hs | (~ls & ext);
   always #2.5 clock = ~clock;
   gpx_host_model gpx_host_model_inst (.clock(clock), .sda_line(sda), .scl(scl),
      .sda_low(sda_low));
   gpx_expander gpx_expander_inst (.clock(clock), .nrst(nrst), .clk_en(1'b1),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel_0(asel[0]), .addr_sel_1(asel[1]), .addr_sel_2(asel[2]),
      .port_in(pins), .high_side_driver(hs), .low_side_driver(ls), .port_oe(poe),
      .alert_out(alert_out), .alert_oe(alert_oe));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] expect_reg(input logic [1:0] r);
      logic [7:0] p;
      p = (m_dir & ext) | (~m_dir & m_out);
      case (r)
         2'h0:    return p ^ m_pol;
         2'h1:    return m_out;
         2'h2:    return m_pol;
         default: return m_dir;
      endcase
   endfunction
   task automatic drivers();
      chk("high side", m_out & ~m_dir, hs);
      chk("low side", ~m_out & ~m_dir, ls);
      chk("pin enable", ~m_dir, poe);
   endtask
   task automatic send(input logic [7:0] d);
      gpx_host_model_inst.xfer(d, 1'b1, rx, ack);
      chk("ack", 8'h01, {7'h0, ack});
   endtask
   task automatic sel_cmd(input logic [1:0] r);
      gpx_host_model_inst.start();
      send({`GPX_ADDR_FIXED, asel, 1'b0});
      send({6'h00, r});
      m_sel = r;
   endtask
   // Writes aimed at the input register leave the model untouched
   task automatic wr_reg(input logic [1:0] r, input logic [7:0] d);
      sel_cmd(r);
      send(d);
      gpx_host_model_inst.stop();
      if (r == 2'h1) m_out = d;
      if (r == 2'h2) m_pol = d;
      if (r == 2'h3) m_dir = d;
   endtask
   task automatic rd_now();
      gpx_host_model_inst.start();
      send({`GPX_ADDR_FIXED, asel, 1'b1});
      gpx_host_model_inst.xfer(8'hff, 1'b1, rx, ack);
      gpx_host_model_inst.stop();
      chk("register", expect_reg(m_sel), rx);
   endtask
   task automatic rd_reg(input logic [1:0] r);
      sel_cmd(r);
      rd_now();
   endtask
   task automatic reset_dut();
      nrst = 1'b0;
      gpx_host_model_inst.pause(5);
      nrst = 1'b1;
      gpx_host_model_inst.pause(4);
      m_out = `GPX_RST_OUTPUT;
      m_pol = `GPX_RST_POLARITY;
      m_dir = `GPX_RST_DIR;
      drivers();
      chk("alert", 8'h00, {7'h0, alert_oe});
      for (int r = 1; r < 4; r++) rd_reg(r[1:0]);
   endtask
   task automatic alert_is(input logic [7:0] e);
      gpx_host_model_inst.pause(8);
      chk("alert", e, {7'h0, alert_oe});
      chk("alert level", 8'h00, {7'h0, alert_out});
   endtask
   initial begin
      reset_dut();
      $display("test reset defaults done");
      gpx_host_model_inst.start();
      gpx_host_model_inst.xfer({`GPX_ADDR_FIXED, ~asel, 1'b0}, 1'b1, rx, ack);
      gpx_host_model_inst.stop();
      chk("foreign ack", 8'h00, {7'h0, ack});
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         asel = v[2:0];
         ext = v[15:8];
         v = $random(seed);
         wr_reg(2'h3, v[7:0]);
         wr_reg(2'h1, v[15:8]);
         wr_reg(2'h2, v[23:16]);
         wr_reg(2'h0, v[31:24]);
         drivers();
         for (int r = 0; r < 4; r++) rd_reg(r[1:0]);
         rd_now();
      end
      $display("test register traffic done");
      wr_reg(2'h3, 8'hff);
      rd_reg(2'h0);
      alert_is(8'h00);
      ext = ext ^ 8'h20;
      alert_is(8'h01);
      ext = ext ^ 8'h20;
      alert_is(8'h00);
      ext = ext ^ 8'h01;
      alert_is(8'h01);
      rd_now();
      alert_is(8'h00);
      $display("test change alert done");
      wr_reg(2'h3, 8'h00);
      gpx_host_model_inst.start();
      send({`GPX_ADDR_FIXED, asel, 1'b0});
      // Reset lands in mid-transfer; the bus must still recover
      reset_dut();
      gpx_host_model_inst.stop();
      rd_reg(2'h3);
      $display("test reset mid-transfer done");
      complete_run();
   end
   initial begin
      #450000;
      n_errors++;
      complete_run();
   end
endmodule
